//--- src/cae_regs.sv
`timescale 1ns/100ps
// How it works
// - parity fault edge of chosen polarity sets misc event bit 3
// - sequence analyzer unlock edge of chosen polarity sets misc event bit 2
// - internal collision edge of chosen polarity sets misc event bit 1
// - external collision edge of chosen polarity sets misc event bit 0
// - an unmasked set event bit drives interrupt and/or internal alarm
// - event bits stay set until host writes zero to them
// - monitor bit sets whenever its fault is present during the second
// - monitor clears on host zero if fault gone, or on tick rise if fault gone and event cleared
// - clock/sync monitor: bits 7-5 receive, 4 reserved, 3-0 master and transmit
// - misc monitor: parity, sequence unlock, internal and external collision
// - channel summary bits 6-0 show channels 7-1 having pending events
// - channel summary bit 7 always reads zero
// - internal collision flagged when two enabled channels share a transmit slot
// - master clock loss after 32 silent processor cycles, clears after 32 present
module cae_regs
	import cae_pkg::*;
#(
	parameter int NUM_CH     = NUM_CH_DEF,
	parameter int SLOT_W     = SLOT_W_DEF,
	parameter int MCK_CYCLES = MCK_LOSS_CYCLES
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic [ADDR_W-1:0]        host_addr,
	input  wire logic                     host_wr,
	input  wire logic                     host_rd,
	input  wire logic [DATA_W-1:0]        host_wdata,
	output logic      [DATA_W-1:0]        host_rdata,
	input  wire logic                     edge_rise_sel,
	input  wire logic                     edge_fall_sel,
	input  wire logic                     rx_parity_fault,
	input  wire logic                     seq_analyzer_unlock,
	input  wire logic                     ext_collision_fault,
	input  wire logic [NUM_CH*SLOT_W-1:0] ch_slot,
	input  wire logic [NUM_CH-1:0]        ch_slot_en,
	input  wire logic                     master_clock_input,
	input  wire logic                     processor_clock_input,
	input  wire logic [DATA_W-1:0]        clk_sync_fault,
	input  wire logic [DATA_W-1:0]        clk_sync_event,
	input  wire logic [NUM_CH-1:0]        ch_pending,
	input  wire logic                     one_second_tick_input,
	input  wire logic [NUM_MISC-1:0]      misc_event_mask,
	input  wire logic                     irq_enable,
	input  wire logic                     alarm_enable,
	output logic                          event_irq,
	output logic                          event_alarm,
	output logic                          master_clock_loss,
	output logic                          internal_collision
);
	// the summary register has one bit per channel 7..1, so the count is fixed
	if (NUM_CH != NUM_CH_DEF) begin : g_bad_ch
		$error("cae_regs: channel summary register holds exactly seven channels");
	end
	// a zero slot width or loss count leaves the detectors nothing to do
	if (SLOT_W < 1 || MCK_CYCLES < 1) begin : g_bad_count
		$error("cae_regs: unsupported slot width or loss count");
	end

	// detector results travel as one bundle
	cae_fault_if flt ();

	// slot collision and master clock loss detectors
	cae_fault_detect #(
		.NUM_CH     (NUM_CH),
		.SLOT_W     (SLOT_W),
		.MCK_CYCLES (MCK_CYCLES)
	) u_detect (
		.sys_clk               (sys_clk),
		.rst                   (rst),
		.ce                    (ce),
		.ch_slot               (ch_slot),
		.ch_slot_en            (ch_slot_en),
		.master_clock_input    (master_clock_input),
		.processor_clock_input (processor_clock_input),
		.flt                   (flt)
	);

	// a host strobe aimed at one register offset
	function automatic logic host_hits(input logic              strobe,
	                                   input logic [ADDR_W-1:0] addr,
	                                   input logic [ADDR_W-1:0] ofs);
		return strobe && addr == ofs;
	endfunction

	// active edge of a condition as chosen by the rise and fall selects
	function automatic logic [NUM_MISC-1:0] active_edge(input logic [NUM_MISC-1:0] now,
	                                                   input logic [NUM_MISC-1:0] prev,
	                                                   input logic rise, input logic fall);
		return ({NUM_MISC{rise}} & now & ~prev) | ({NUM_MISC{fall}} & ~now & prev);
	endfunction

	// one-second monitor update; a set from a live fault beats any clear
	function automatic logic [DATA_W-1:0] pm_next(input logic [DATA_W-1:0] pm,
	                                              input logic [DATA_W-1:0] fault,
	                                              input logic [DATA_W-1:0] evt,
	                                              input logic              wr_hit,
	                                              input logic [DATA_W-1:0] wdata,
	                                              input logic              tick);
		logic [DATA_W-1:0] v;
		// both clears first, so a live fault always sets its bit again
		v = pm;
		if (wr_hit)
			v = v & wdata;
		if (tick)
			v = v & (fault | evt);
		v = v | fault;
		return v;
	endfunction

	// registered state
	logic [NUM_MISC-1:0] misc_ev_q, misc_ev_d;
	logic [NUM_MISC-1:0] misc_prev_q, misc_prev_d;
	logic [DATA_W-1:0]   misc_pm_q, misc_pm_d;
	logic [DATA_W-1:0]   cs_pm_q, cs_pm_d;
	logic                tick_prev_q, tick_prev_d;
	logic                irq_q, irq_d;
	logic                alarm_q, alarm_d;
	logic [DATA_W-1:0]   rdata_q, rdata_d;

	// live conditions in register layout
	logic [NUM_MISC-1:0] misc_fault;
	logic [DATA_W-1:0]   misc_fault_b;
	logic [DATA_W-1:0]   misc_ev_b;
	logic [DATA_W-1:0]   cs_fault;
	logic [DATA_W-1:0]   cs_evt;
	logic                tick_rise;

	// gather live conditions into register layout
	always_comb begin
		misc_fault                 = MISC_ZERO;
		misc_fault[BIT_RX_PARITY]  = rx_parity_fault;
		misc_fault[BIT_SEQ_UNLOCK] = seq_analyzer_unlock;
		misc_fault[BIT_INT_COLL]   = flt.internal_collision;
		misc_fault[BIT_EXT_COLL]   = ext_collision_fault;
		misc_fault_b               = {{(DATA_W-NUM_MISC){1'b0}}, misc_fault};
		misc_ev_b                  = {{(DATA_W-NUM_MISC){1'b0}}, misc_ev_q};
		// bit 3 comes from our own loss detector; the reserved bit never sets
		cs_fault                   = clk_sync_fault;
		cs_fault[BIT_CS_MCK]       = flt.master_clock_loss;
		cs_fault                   = cs_fault & ~CS_RSVD_MASK;
		cs_evt                     = clk_sync_event & ~CS_RSVD_MASK;
		tick_rise                  = one_second_tick_input & ~tick_prev_q;
	end

	// event latches, monitors and alarm outputs
	always_comb begin
		logic wr_ev;
		logic wr_cs;
		logic wr_mp;
		logic unmasked;
		wr_ev       = host_hits(host_wr, host_addr, OFS_MISC_EVENT);
		wr_cs       = host_hits(host_wr, host_addr, OFS_CS_PM);
		wr_mp       = host_hits(host_wr, host_addr, OFS_MISC_PM);
		unmasked    = 1'b0;
		misc_prev_d = misc_fault;
		tick_prev_d = one_second_tick_input;
		misc_ev_d   = misc_ev_q;
		// reserved high bits are simply not stored, so stray ones do no harm
		if (wr_ev)
			misc_ev_d = misc_ev_q & host_wdata[NUM_MISC-1:0];
		// set after clear so a coincident edge is kept
		misc_ev_d = misc_ev_d | active_edge(misc_fault, misc_prev_q, edge_rise_sel, edge_fall_sel);
		// a tick clears a monitor only once its event bit is gone as well
		misc_pm_d = pm_next(misc_pm_q, misc_fault_b, misc_ev_b, wr_mp, host_wdata, tick_rise);
		cs_pm_d   = pm_next(cs_pm_q, cs_fault, cs_evt, wr_cs, host_wdata, tick_rise);
		// irq and alarm share one pending term, each behind its own enable
		unmasked  = |(misc_ev_d & ~misc_event_mask);
		irq_d     = irq_enable & unmasked;
		alarm_d   = alarm_enable & unmasked;
	end

	// read data; spares and unmapped offsets answer zero
	always_comb begin
		rdata_d = rdata_q;
		// rdata holds between reads, so a slow host may sample it late
		if (host_rd) begin
			unique case (host_addr)
				OFS_MISC_EVENT: rdata_d = misc_ev_b;
				OFS_CS_PM:      rdata_d = cs_pm_q;
				OFS_MISC_PM:    rdata_d = misc_pm_q;
				OFS_CH_PENDING: rdata_d = {1'b0, ch_pending};
				OFS_SPARE_LOW:  rdata_d = BYTE_ZERO;
				OFS_SPARE_HIGH: rdata_d = BYTE_ZERO;
				default:        rdata_d = BYTE_ZERO;
			endcase
		end
	end

	// ce low freezes every register, read data included
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			misc_ev_q   <= MISC_ZERO;
			misc_prev_q <= MISC_ZERO;
			misc_pm_q   <= BYTE_ZERO;
			cs_pm_q     <= BYTE_ZERO;
			tick_prev_q <= 1'b0;
			irq_q       <= 1'b0;
			alarm_q     <= 1'b0;
			rdata_q     <= BYTE_ZERO;
		end else if (ce) begin
			misc_ev_q   <= misc_ev_d;
			misc_prev_q <= misc_prev_d;
			misc_pm_q   <= misc_pm_d;
			cs_pm_q     <= cs_pm_d;
			tick_prev_q <= tick_prev_d;
			irq_q       <= irq_d;
			alarm_q     <= alarm_d;
			rdata_q     <= rdata_d;
		end
	end

	// outputs come straight from flops; loss and collision are registered in the detector
	assign host_rdata         = rdata_q;
	assign event_irq          = irq_q;
	assign event_alarm        = alarm_q;
	assign master_clock_loss  = flt.master_clock_loss;
	assign internal_collision = flt.internal_collision;
endmodule

//--- src/cae_pkg.sv
package cae_pkg;
	// host port geometry
	localparam int        ADDR_W         = 5;
	localparam int        DATA_W         = 8;
	localparam logic [ADDR_W-1:0] OFS_MISC_EVENT = 5'h0d;
	localparam logic [ADDR_W-1:0] OFS_CS_PM      = 5'h0e;
	localparam logic [ADDR_W-1:0] OFS_MISC_PM    = 5'h0f;
	localparam logic [ADDR_W-1:0] OFS_SPARE_LOW  = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_CH_PENDING = 5'h11;
	localparam logic [ADDR_W-1:0] OFS_SPARE_HIGH = 5'h12;

	// bus/misc event and monitor bit positions
	localparam int        NUM_MISC       = 4;
	localparam int        BIT_RX_PARITY  = 3;
	localparam int        BIT_SEQ_UNLOCK = 2;
	localparam int        BIT_INT_COLL   = 1;
	localparam int        BIT_EXT_COLL   = 0;

	// clock/sync monitor layout
	localparam int        BIT_CS_RSVD    = 4;
	localparam int        BIT_CS_MCK     = 3;
	localparam logic [DATA_W-1:0] CS_RSVD_MASK = 8'h10;

	// channel summary
	localparam int        NUM_CH_DEF     = 7;
	localparam int        SLOT_W_DEF     = 7;

	// master clock loss detect/clear, in processor clock cycles
	localparam int        MCK_LOSS_CYCLES = 32;

	localparam logic [DATA_W-1:0]   BYTE_ZERO = 8'h00;
	localparam logic [NUM_MISC-1:0] MISC_ZERO = 4'h0;

	typedef enum logic {
		CAE_MCK_PRESENT = 1'b0,
		CAE_MCK_LOST    = 1'b1
	} cae_mck_state_t;
endpackage

//--- src/cae_fault_if.sv
`timescale 1ns/100ps
interface cae_fault_if;
	logic internal_collision;
	logic master_clock_loss;

	modport det (output internal_collision, output master_clock_loss);
	modport regs (input internal_collision, input master_clock_loss);
endinterface

//--- src/cae_fault_detect.sv
`timescale 1ns/100ps
module cae_fault_detect
	import cae_pkg::*;
#(
	parameter int NUM_CH     = NUM_CH_DEF,
	parameter int SLOT_W     = SLOT_W_DEF,
	parameter int MCK_CYCLES = MCK_LOSS_CYCLES
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic [NUM_CH*SLOT_W-1:0] ch_slot,
	input  wire logic [NUM_CH-1:0]        ch_slot_en,
	input  wire logic                     master_clock_input,
	input  wire logic                     processor_clock_input,
	cae_fault_if.det                      flt
);
	localparam int CNT_W = $clog2(MCK_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(MCK_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_ZERO  = CNT_W'(0);

	// a collision needs two channels, and the loss count must be at least one
	if (NUM_CH < 2 || SLOT_W < 1 || MCK_CYCLES < 1) begin : g_bad_params
		$error("cae_fault_detect: unsupported parameters");
	end

	// any two enabled channels on one transmit slot
	function automatic logic slots_collide(input logic [NUM_CH*SLOT_W-1:0] s, input logic [NUM_CH-1:0] en);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			for (int j = i + 1; j < NUM_CH; j++) begin
				if (en[i] && en[j] && s[i*SLOT_W +: SLOT_W] == s[j*SLOT_W +: SLOT_W])
					hit = 1'b1;
			end
		end
		return hit;
	endfunction

	cae_mck_state_t   state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic             mck_prev_q, mck_prev_d;
	logic             pck_prev_q, pck_prev_d;
	logic             seen_q, seen_d;
	logic             coll_q, coll_d;

	// loss detector counts processor clock edges, master clock toggles sampled on sys_clk
	always_comb begin
		logic mck_toggle;
		logic pck_rise;
		logic seen_now;
		mck_toggle = master_clock_input ^ mck_prev_q;
		pck_rise   = processor_clock_input & ~pck_prev_q;
		seen_now   = seen_q | mck_toggle;
		mck_prev_d = master_clock_input;
		pck_prev_d = processor_clock_input;
		state_d    = state_q;
		cnt_d      = cnt_q;
		seen_d     = seen_now;
		coll_d     = slots_collide(ch_slot, ch_slot_en);
		unique case (state_q)
			CAE_MCK_PRESENT: begin
				// no stale toggle may count toward the first clear interval
				seen_d = 1'b0;
				if (mck_toggle) begin
					cnt_d = CNT_ZERO;
				end else if (pck_rise) begin
					cnt_d = cnt_q + CNT_ONE;
					if (cnt_q + CNT_ONE >= CNT_LIMIT) begin
						state_d = CAE_MCK_LOST;
						cnt_d   = CNT_ZERO;
					end
				end
			end
			CAE_MCK_LOST: begin
				if (pck_rise) begin
					seen_d = 1'b0;
					// a silent interval restarts the clear count
					if (!seen_now) begin
						cnt_d = CNT_ZERO;
					end else if (cnt_q + CNT_ONE >= CNT_LIMIT) begin
						state_d = CAE_MCK_PRESENT;
						cnt_d   = CNT_ZERO;
					end else begin
						cnt_d = cnt_q + CNT_ONE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q    <= CAE_MCK_PRESENT;
			cnt_q      <= CNT_ZERO;
			mck_prev_q <= 1'b0;
			pck_prev_q <= 1'b0;
			seen_q     <= 1'b0;
			coll_q     <= 1'b0;
		end else if (ce) begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			mck_prev_q <= mck_prev_d;
			pck_prev_q <= pck_prev_d;
			seen_q     <= seen_d;
			coll_q     <= coll_d;
		end
	end

	assign flt.internal_collision = coll_q;
	assign flt.master_clock_loss  = (state_q == CAE_MCK_LOST);
endmodule

//--- testbench/cae_regs_sva.sv
`timescale 1ns/100ps
module cae_regs_sva
	import cae_pkg::*;
#(
	parameter int NUM_CH     = NUM_CH_DEF,
	parameter int SLOT_W     = SLOT_W_DEF,
	parameter int MCK_CYCLES = MCK_LOSS_CYCLES
) (
	input wire logic                     sys_clk,
	input wire logic                     rst,
	input wire logic [ADDR_W-1:0]        host_addr,
	input wire logic                     host_wr,
	input wire logic                     host_rd,
	input wire logic [DATA_W-1:0]        host_rdata,
	input wire logic                     edge_rise_sel,
	input wire logic                     edge_fall_sel,
	input wire logic                     rx_parity_fault,
	input wire logic                     seq_analyzer_unlock,
	input wire logic                     ext_collision_fault,
	input wire logic [NUM_CH*SLOT_W-1:0] ch_slot,
	input wire logic [NUM_CH-1:0]        ch_slot_en,
	input wire logic [NUM_CH-1:0]        ch_pending,
	input wire logic [NUM_MISC-1:0]      misc_event_mask,
	input wire logic                     irq_enable,
	input wire logic                     alarm_enable,
	input wire logic                     event_irq,
	input wire logic                     event_alarm,
	input wire logic                     internal_collision
);
	logic coll;

	// own pairwise slot compare, so a slip in the design's compare shows
	always_comb begin
		coll = 1'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			for (int j = i + 1; j < NUM_CH; j++)
				coll |= ch_slot_en[i] & ch_slot_en[j] & (ch_slot[i*SLOT_W+:SLOT_W] == ch_slot[j*SLOT_W+:SLOT_W]);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// selected edge on an unmasked source must show on the interrupt next cycle
	property p_evt(logic f, int b);
		irq_enable && !misc_event_mask[b] && ((edge_rise_sel && $rose(f)) || (edge_fall_sel && $fell(f))) |=> event_irq;
	endproperty

	a_parity_evt_irq: assert property (p_evt(rx_parity_fault, BIT_RX_PARITY))
		else $error("parity edge gave no interrupt");
	a_unlock_evt_irq: assert property (p_evt(seq_analyzer_unlock, BIT_SEQ_UNLOCK))
		else $error("unlock edge gave no interrupt");
	a_intcoll_evt_irq: assert property (irq_enable && !misc_event_mask[BIT_INT_COLL] && edge_rise_sel
		&& $rose(internal_collision) |-> ##[1:2] event_irq) else $error("collision edge gave no interrupt");
	a_extcoll_evt_irq: assert property (p_evt(ext_collision_fault, BIT_EXT_COLL))
		else $error("external collision edge gave no interrupt");
	a_alarm_tracks_irq: assert property ($past(irq_enable) && $past(alarm_enable) |-> event_alarm == event_irq)
		else $error("alarm and interrupt disagree");
	a_event_stays_set: assert property (event_irq && irq_enable && misc_event_mask == MISC_ZERO
		&& !(host_wr && host_addr == OFS_MISC_EVENT) |=> event_irq) else $error("event dropped without host clear");
	a_summary_read: assert property (host_rd && host_addr == OFS_CH_PENDING |=> host_rdata == {1'h0, $past(ch_pending)})
		else $error("channel summary read wrong");
	a_coll_flag: assert property (1'h1 |=> internal_collision == $past(coll))
		else $error("collision flag wrong");

	c_alarm_only: cover property (event_alarm && !event_irq);
	c_collision: cover property (internal_collision);
	c_summary: cover property (host_rd && host_addr == OFS_CH_PENDING);
endmodule

//--- testbench/cae_host_model.sv
`timescale 1ns/100ps
module cae_host_model
	import cae_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic [DATA_W-1:0] host_rdata,
	output logic      [ADDR_W-1:0] host_addr,
	output logic                   host_wr,
	output logic                   host_rd,
	output logic      [DATA_W-1:0] host_wdata
);
	// idle bus: strobes low
	initial begin
		host_addr = OFS_CH_PENDING;
		host_wr = 1'h0;
		host_rd = 1'h0;
		host_wdata = 8'h00;
	end

	// spares never touched; reserved bits always go out as zero
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		if (a != OFS_SPARE_LOW && a != OFS_SPARE_HIGH) begin
			@(negedge sys_clk);
			host_addr = a;
			host_wdata = d & ((a == OFS_CS_PM) ? ~CS_RSVD_MASK : 8'h0f);
			host_wr = 1'h1;
			@(negedge sys_clk);
			host_wr = 1'h0;
			host_wdata = ~host_wdata;
		end
	endtask

	// read data is registered, so it is taken one cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		d = 8'h00;
		if (a != OFS_SPARE_LOW && a != OFS_SPARE_HIGH) begin
			@(negedge sys_clk);
			host_addr = a;
			host_rd = 1'h1;
			@(negedge sys_clk);
			d = host_rdata;
			host_rd = 1'h0;
		end
	endtask
endmodule

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
	import cae_pkg::*;
	localparam int MCK = 4;
	typedef struct packed {
		logic       rise;
		logic       fall;
		logic [3:0] pre;
		logic [3:0] post;
		logic [7:0] exp;
	} cae_row_t;
	logic              sys_clk = 1'h0, rst = 1'h1, tick = 1'h0, pclk = 1'h0, mck = 1'h0, mck_run = 1'h1;
	logic              ce = 1'h1;
	logic              edge_rise_sel = 1'h1, edge_fall_sel = 1'h0, irq_enable = 1'h1, alarm_enable = 1'h1;
	logic [3:0]        flt = 4'h0, misc_event_mask = 4'h0;
	logic [48:0]       ch_slot = 49'h0;
	logic [6:0]        ch_slot_en = 7'h00, ch_pending = 7'h00;
	logic [7:0]        cs_fault = 8'h00, cs_evt = 8'h00, rdv, host_wdata, host_rdata;
	logic [ADDR_W-1:0] host_addr;
	logic              host_wr, host_rd, event_irq, event_alarm, master_clock_loss, internal_collision;
	int                miscompares = 0, n_compared = 0, cyc = 0;
	cae_row_t          rows [5] = '{'{1'h1, 1'h0, 4'h0, 4'h8, 8'h08}, '{1'h0, 1'h1, 4'h4, 4'h0, 8'h04},
		'{1'h1, 1'h0, 4'h1, 4'h0, 8'h00}, '{1'h1, 1'h1, 4'h0, 4'h1, 8'h01}, '{1'h0, 1'h0, 4'h0, 4'hd, 8'h00}};

	cae_regs #(.MCK_CYCLES(MCK)) i_cae_regs (
		.sys_clk, .rst, .ce, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
		.edge_rise_sel, .edge_fall_sel, .rx_parity_fault(flt[3]), .seq_analyzer_unlock(flt[2]),
		.ext_collision_fault(flt[0]), .ch_slot, .ch_slot_en, .master_clock_input(mck),
		.processor_clock_input(pclk), .clk_sync_fault(cs_fault), .clk_sync_event(cs_evt), .ch_pending,
		.one_second_tick_input(tick), .misc_event_mask, .irq_enable, .alarm_enable, .event_irq,
		.event_alarm, .master_clock_loss, .internal_collision);
	cae_host_model host (.sys_clk, .host_rdata, .host_addr, .host_wr, .host_rd, .host_wdata);

	// clocks: processor clock at half rate, master clock toggles while running
	always #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		pclk <= ~pclk;
		mck <= mck ^ mck_run;
	end
	// hang guard, far above the roughly 155 cycles the run needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		host.rd(a, rdv);
		chk(rdv, exp);
	endtask
	task automatic tick_pulse();
		tick = 1'h1;
		step(2);
		tick = 1'h0;
		step(1);
	endtask
	task automatic print_verdict();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		step(8);
		rst = 1'h0;
		// edge table: old edges are cleared first, so only the row's edge counts
		foreach (rows[i]) begin
			{edge_rise_sel, edge_fall_sel, flt} = {rows[i].rise, rows[i].fall, rows[i].pre};
			step(2);
			host.wr(OFS_MISC_EVENT, 8'h00);
			flt = rows[i].post;
			step(2);
			rchk(OFS_MISC_EVENT, rows[i].exp);
			chk({7'h0, event_irq}, {7'h0, rows[i].exp != 8'h00});
		end
		// one-second monitors hold while the fault lives
		rchk(OFS_MISC_PM, 8'h0d);
		tick_pulse();
		rchk(OFS_MISC_PM, 8'h0d);
		flt = 4'h0;
		tick_pulse();
		rchk(OFS_MISC_PM, 8'h00);
		// two enabled channels on one slot
		edge_rise_sel = 1'h1;
		ch_slot = {21'h0, 7'h05, 14'h0, 7'h05};
		ch_slot_en = 7'h09;
		step(3);
		chk({7'h0, internal_collision}, 8'h01);
		rchk(OFS_MISC_EVENT, 8'h02);
		ch_slot_en = 7'h01;
		step(2);
		chk({7'h0, internal_collision}, 8'h00);
		host.wr(OFS_MISC_EVENT, 8'h0f);
		tick_pulse();
		rchk(OFS_MISC_EVENT, 8'h02);
		rchk(OFS_MISC_PM, 8'h02);
		host.wr(OFS_MISC_PM, 8'h0f);
		rchk(OFS_MISC_PM, 8'h02);
		host.wr(OFS_MISC_EVENT, 8'h00);
		rchk(OFS_MISC_EVENT, 8'h00);
		tick_pulse();
		rchk(OFS_MISC_PM, 8'h00);
		// host zero clears a monitor; then mask and alarm-only routing
		flt = 4'h8;
		step(2);
		flt = 4'h0;
		host.wr(OFS_MISC_PM, 8'h00);
		rchk(OFS_MISC_PM, 8'h00);
		misc_event_mask = 4'h8;
		step(2);
		chk({6'h0, event_irq, event_alarm}, 8'h00);
		{misc_event_mask, irq_enable} = 5'h00;
		step(2);
		chk({6'h0, event_irq, event_alarm}, 8'h01);
		// clock/sync monitor layout and master clock loss timing
		cs_fault = 8'hff;
		step(2);
		rchk(OFS_CS_PM, 8'he7);
		{cs_fault, mck_run} = 9'h000;
		step(5);
		chk({7'h0, master_clock_loss}, 8'h00);
		step(7);
		chk({7'h0, master_clock_loss}, 8'h01);
		mck_run = 1'h1;
		step(14);
		chk({7'h0, master_clock_loss}, 8'h00);
		rchk(OFS_CS_PM, 8'hef);
		cs_evt = 8'h08;
		tick_pulse();
		rchk(OFS_CS_PM, 8'h08);
		cs_evt = 8'h00;
		tick_pulse();
		rchk(OFS_CS_PM, 8'h00);
		// channel summary, top bit stays zero
		ch_pending = 7'h7f;
		rchk(OFS_CH_PENDING, 8'h7f);
		ch_pending = 7'h2a;
		rchk(OFS_CH_PENDING, 8'h2a);
		// ce low freezes the bank: a host clear then goes unheard
		flt = 4'h8;
		step(2);
		ce = 1'h0;
		host.wr(OFS_MISC_EVENT, 8'h00);
		ce = 1'h1;
		rchk(OFS_MISC_EVENT, 8'h08);
		// reset in mid-run wipes a set event
		{rst, flt} = 5'h10;
		step(2);
		rst = 1'h0;
		rchk(OFS_MISC_EVENT, 8'h00);
		print_verdict();
	end
endmodule

bind cae_regs cae_regs_sva #(.NUM_CH(NUM_CH), .SLOT_W(SLOT_W), .MCK_CYCLES(MCK_CYCLES)) i_cae_regs_sva (
	.sys_clk, .rst, .host_addr, .host_wr, .host_rd, .host_rdata, .edge_rise_sel, .edge_fall_sel,
	.rx_parity_fault, .seq_analyzer_unlock, .ext_collision_fault, .ch_slot, .ch_slot_en, .ch_pending,
	.misc_event_mask, .irq_enable, .alarm_enable, .event_irq, .event_alarm, .internal_collision);
